//--- dv/serial_tx_model.sv
// Behavioural serial transmitter that drives the probed line.
`timescale 1ns/1ps
module serial_tx_model (
    input  wire logic clk_i,
    output logic      line_o
);
    int unsigned div = 8;

    // The line idles high, as a transmitter between frames leaves it.
    initial line_o = 1'b1;

    // Holds one level for a number of half bit periods.
    task automatic hold(input logic v, input int halves);
        line_o <= v;
        repeat (halves * div / 2) @(posedge clk_i);
    endtask : hold

    // Sends start, data LSB first, optional parity and one stop bit.
    task automatic send(input logic [8:0] v, input int width, input int par,
                        input bit bad_par, input bit bad_stop);
        logic p;
        p = ^(v & 9'((1 << width) - 1));
        hold(1'b0, 2);
        for (int i = 0; i < width; i++) hold(v[i], 2);
        if (par != 0) hold(logic'(par == 2) ^ p ^ bad_par, 2);
        hold(!bad_stop, 2);
        if (bad_stop) hold(1'b1, 2);
    endtask : send

    // Holds the line low where stop bits would stand, then releases it.
    task automatic brk(input int n);
        hold(1'b0, 2 * n);
        hold(1'b1, 2);
    endtask : brk
endmodule : serial_tx_model

//--- dv/test_async_serial_trigger_decoder.sv
// Self-checking bench for the serial trigger decoder.
`timescale 1ns/1ps
module test_async_serial_trigger_decoder;
    import uart_trig_pkg::*;
    logic        clk_i     = 1'b0;
    logic        reset_i   = 1'b1;
    logic        capture_i = 1'b1;
    bus_req_t    bus_i     = '0;
    logic        line;
    logic [31:0] rdata_o;
    logic        trigger_o;
    logic        break_o;
    logic        frame_valid_o;
    frame_rec_t  frame_o;
    frame_rec_t  last_rec;
    int          miscompares = 0;
    int          checks_done = 0;
    int          trigs       = 0;
    int          frames      = 0;

    uart_trig_decoder dut (.clk_i(clk_i), .reset_i(reset_i), .line_i(line),
        .capture_i(capture_i), .bus_i(bus_i), .rdata_o(rdata_o), .trigger_o(trigger_o),
        .break_o(break_o), .frame_o(frame_o), .frame_valid_o(frame_valid_o));
    serial_tx_model tx (.clk_i(clk_i), .line_o(line));

    // Clock at 40 MHz.
    initial forever #12.5 clk_i = ~clk_i;

    // Counts every high trigger cycle, so a stretched pulse shows as extra.
    always @(posedge clk_i) begin
        if (trigger_o === 1'b1) trigs++;
        if (frame_valid_o === 1'b1) begin
            frames++;
            last_rec = frame_o;
        end
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_i) bus_i <= '0;
    endtask : wr

    // Read data stand only in the cycle after the strobe, so sample mid-cycle.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i) bus_i <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_i) bus_i <= '0;
        @(negedge clk_i) check("rdata", rdata_o, exp);
    endtask : rd

    // Selects a mode with 8-bit symbols and trigger enabled.
    task automatic mode(input logic [31:0] m);
        wr(OFF_CTRL, 32'h0000_1080 | m);
        trigs = 0;
        frames = 0;
    endtask : mode

    // Idle long enough to close the frame and clear the idle gap.
    task automatic idle();
        repeat (150) @(posedge clk_i);
    endtask : idle

    task automatic t_regs();
        rd(OFF_CTRL, 32'(CTRL_RESET));
        rd(OFF_DIV, 32'(DIV_RESET));
        rd(8'hFC, 32'h0000_0000);
        wr(OFF_DIV, 32'h0000_0008);
        wr(OFF_IDLE, 32'h0000_0040);
        wr(OFF_BREAK, 32'h0000_00C8);
        rd(OFF_DIV, 32'h0000_0008);
        idle();
    endtask : t_regs

    task automatic t_start();
        mode(32'(TM_START));
        tx.send(9'h0A5, 8, 0, 0, 0);
        tx.send(9'h03C, 8, 0, 0, 0);
        idle();
        check("start triggers", trigs, 2);
        check("frames", frames, 1);
        check("words", 32'(last_rec.words), 2);
        check("state", 32'(last_rec.state), 32'(FS_VALID));
        check("last word", 32'(last_rec.last_word), 32'h0000_003C);
        // The frame opened one symbol of ten 8-cycle bits before the last start trigger.
        rd(OFF_REL, 32'hFFFF_FFB0);
        wr(OFF_DATA, 32'h0000_0000);
        rd(OFF_DATA, 32'h0000_00A5);
        mode(32'(TM_FRAME));
        tx.send(9'h0A5, 8, 0, 0, 0);
        tx.send(9'h03C, 8, 0, 0, 0);
        idle();
        check("frame triggers", trigs, 1);
    endtask : t_start

    task automatic t_symbols();
        wr(OFF_NTH, 32'h0000_0002);
        mode(32'(TM_NTH));
        for (int i = 0; i < 4; i++) tx.send(9'(8'h11 * i), 8, 0, 0, 0);
        idle();
        check("nth triggers", trigs, 1);
        wr(OFF_REF0, 32'h000F_005A);
        mode(32'(TM_ANY));
        tx.send(9'h05A, 8, 0, 0, 0);
        tx.send(9'h03A, 8, 0, 0, 0);
        tx.send(9'h05B, 8, 0, 0, 0);
        idle();
        check("any triggers", trigs, 2);
        // Five-bit symbols: reference bits above the width must not matter.
        wr(OFF_REF0, 32'h01FF_00F5);
        wr(OFF_CTRL, 32'h0000_1053);
        trigs = 0;
        tx.send(9'h015, 5, 0, 0, 0);
        tx.send(9'h014, 5, 0, 0, 0);
        idle();
        check("width 5 triggers", trigs, 1);
    endtask : t_symbols

    // Each parity rule sees one good and one bad symbol.
    task automatic t_errors();
        for (int p = 1; p < 3; p++) begin
            mode(32'(TM_PARITY) | 32'(p << 8));
            tx.send(9'h0B7, 8, p, 0, 0);
            tx.send(9'h0B7, 8, p, 1, 0);
            idle();
            check("parity triggers", trigs, 1);
        end
        mode(32'(TM_FRAMEERR));
        tx.send(9'h055, 8, 0, 0, 1);
        idle();
        check("frame error triggers", trigs, 1);
        // Two stop bits: an extra high bit passes, a start in the second slot does not.
        mode(32'(TM_FRAMEERR) | 32'h0000_0800);
        tx.send(9'h055, 8, 0, 0, 0);
        tx.hold(1'b1, 2);
        tx.send(9'h0FF, 8, 0, 0, 0);
        idle();
        tx.send(9'h055, 8, 0, 0, 0);
        tx.send(9'h0FF, 8, 0, 0, 0);
        idle();
        check("two stop errors", trigs, 1);
        mode(32'(TM_BREAK));
        tx.brk(300);
        check("break flag", 32'(break_o), 1);
        check("break triggers", trigs, 1);
        idle();
    endtask : t_errors

    // Offset one, two symbols; hex entry then makes the second symbol wholly don't-care.
    task automatic t_pattern();
        wr(OFF_PAT, 32'h0000_2001);
        wr(OFF_REF0, 32'h01FF_0011);
        wr(OFF_REF0 + REF_STEP, 32'h01FF_0022);
        mode(32'(TM_PATTERN));
        for (int i = 0; i < 4; i++) tx.send(9'(8'h11 * i), 8, 0, 0, 0);
        idle();
        check("pattern triggers", trigs, 1);
        wr(OFF_PAT, 32'h0001_2001);
        wr(OFF_REF0 + REF_STEP, 32'h01FE_0099);
        mode(32'(TM_PATTERN));
        tx.send(9'h000, 8, 0, 0, 0);
        tx.send(9'h011, 8, 0, 0, 0);
        tx.send(9'h044, 8, 0, 0, 0);
        idle();
        check("hex pattern triggers", trigs, 1);
    endtask : t_pattern

    // A frame that starts outside the capture window is only partly valid.
    task automatic t_capture();
        mode(32'(TM_START));
        capture_i <= 1'b0;
        tx.send(9'h012, 8, 0, 0, 0);
        idle();
        capture_i <= 1'b1;
        check("capture frames", frames, 1);
        check("capture state", 32'(last_rec.state), 32'(FS_INCOMPLETE));
    endtask : t_capture

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // Watchdog, well beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_start();
        t_symbols();
        t_errors();
        t_pattern();
        t_capture();
        print_verdict();
    end
endmodule : test_async_serial_trigger_decoder

//--- verilog/line_sync.sv
// Two-stage synchroniser for the probed line, followed by polarity mapping.
`timescale 1ns/1ps
module line_sync (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic line_i,
    input  wire logic active_low_i,
    output logic      bit_o
);
    logic meta;
    logic stable;

    // The first stage feeds only the second one.
    always_ff @(posedge clk_i) begin
        meta   <= reset_i ? 1'b1 : line_i;
        stable <= reset_i ? 1'b1 : meta;
    end

    // With active low a low level is logic one, as on an RS-232 line.
    assign bit_o = active_low_i ? ~stable : stable;
endmodule : line_sync

//--- verilog/symbol_match.sv
// Three-state comparison of one received symbol with one reference symbol.
`timescale 1ns/1ps
module symbol_match (
    input  wire logic [8:0] sym_i,
    input  wire logic [8:0] ref_i,
    input  wire logic [8:0] care_i,
    input  wire logic [8:0] width_mask_i,
    input  wire logic       hex_i,
    output logic            hit_o
);
    logic [8:0] eff_care;

    // Hex entry carries one don't-care flag for the whole symbol.
    assign eff_care = hex_i ? {9{care_i[0]}} : care_i;
    // Bits above the symbol width and don't-care bits match anything.
    assign hit_o = (((sym_i ^ ref_i) & eff_care & width_mask_i) == 9'h000);
endmodule : symbol_match

//--- verilog/uart_trig_decoder.sv
// Passive asynchronous serial decoder with trigger and frame capture.
`timescale 1ns/1ps
module uart_trig_decoder
    import uart_trig_pkg::*;
#(
    parameter int WORDS = 16
) (
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic       line_i,
    input  wire logic       capture_i,
    input  wire bus_req_t   bus_i,
    output logic [31:0]     rdata_o,
    output logic            trigger_o,
    output logic            break_o,
    output frame_rec_t      frame_o,
    output logic            frame_valid_o
);
    typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP, RX_STOP2, RX_BREAK} rx_state_t;

    // Software registers.
    logic [15:0] ctrl;
    logic [15:0] bit_div;
    logic [19:0] idle_cyc;
    logic [23:0] break_cyc;
    logic [11:0] nth_num;
    logic [16:0] pat_cfg;
    logic [3:0]  data_idx;

    // Receiver state.
    rx_state_t   state;
    logic [15:0] bit_cnt;
    logic [3:0]  bit_idx;
    logic [8:0]  shreg;
    logic [23:0] since_start;
    logic [19:0] idle_cnt;
    logic        frame_open;
    logic        new_frame;
    logic        par_err;
    logic        brk_seen;
    logic [12:0] sym_idx;
    logic        pat_ok;
    logic [31:0] tstamp;
    logic [31:0] trig_time;
    logic        cap_q;
    logic        incomplete;
    logic [8:0]  words [WORDS];

    // Configuration fields.
    wire trig_mode_t mode     = trig_mode_t'(ctrl[CTRL_MODE_LSB +: 3]);
    wire parity_t    par_mode = parity_t'(ctrl[CTRL_PAR_LSB +: 2]);
    wire stop_len_t  stop_len = stop_len_t'(ctrl[CTRL_STOP_LSB +: 2]);
    wire logic [3:0] width_raw = ctrl[CTRL_WID_LSB +: 4];
    wire logic [3:0] width = (width_raw < 4'd5) ? 4'd5 :
                             (width_raw > 4'd9) ? 4'd9 : width_raw;
    wire logic       enable   = ctrl[CTRL_EN_BIT];
    wire logic [11:0] pat_off = pat_cfg[11:0];
    wire logic [1:0] pat_cnt  = (pat_cfg[PAT_CNT_LSB +: 2] == 2'd0) ? 2'd1
                                : pat_cfg[PAT_CNT_LSB +: 2];
    wire logic       hex_mode = pat_cfg[PAT_HEX_BIT];

    // Register write decode.
    wire wr_ctrl  = bus_i.wr && (bus_i.addr == OFF_CTRL);
    wire wr_div   = bus_i.wr && (bus_i.addr == OFF_DIV);
    wire wr_idle  = bus_i.wr && (bus_i.addr == OFF_IDLE);
    wire wr_break = bus_i.wr && (bus_i.addr == OFF_BREAK);
    wire wr_nth   = bus_i.wr && (bus_i.addr == OFF_NTH);
    wire wr_pat   = bus_i.wr && (bus_i.addr == OFF_PAT);
    wire wr_data  = bus_i.wr && (bus_i.addr == OFF_DATA);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl      <= CTRL_RESET;
            bit_div   <= DIV_RESET;
            idle_cyc  <= IDLE_RESET;
            break_cyc <= BREAK_RESET;
            nth_num   <= 12'h000;
            pat_cfg   <= PAT_RESET;
            data_idx  <= 4'h0;
        end else begin
            if (wr_ctrl)  ctrl      <= bus_i.wdata[15:0];
            if (wr_div)   bit_div   <= bus_i.wdata[15:0];
            if (wr_idle)  idle_cyc  <= bus_i.wdata[19:0];
            if (wr_break) break_cyc <= bus_i.wdata[23:0];
            if (wr_nth)   nth_num   <= bus_i.wdata[11:0];
            if (wr_pat)   pat_cfg   <= bus_i.wdata[16:0];
            if (wr_data)  data_idx  <= bus_i.wdata[3:0];
        end
    end

    // Received symbol, right aligned, and the mask of its valid bits.
    wire logic [8:0] width_mask = 9'h1FF >> (4'd9 - width);
    wire logic [8:0] sym_val    = (shreg >> (4'd9 - width)) & width_mask;

    // The three reference symbols share one register layout; each slot owns its registers.
    logic [2:0] ref_hit;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ref
            logic [8:0] ref_val;
            logic [8:0] ref_care;
            wire wr_ref = bus_i.wr && (bus_i.addr == OFF_REF0 + 8'(gi) * REF_STEP);
            always_ff @(posedge clk_i) begin
                if (reset_i) begin
                    ref_val  <= 9'h000;
                    ref_care <= 9'h000;
                end else if (wr_ref) begin
                    ref_val  <= bus_i.wdata[8:0];
                    ref_care <= bus_i.wdata[REF_CARE_LSB +: 9];
                end
            end
            symbol_match u_match (
                .sym_i        (sym_val),
                .ref_i        (ref_val),
                .care_i       (ref_care),
                .width_mask_i (width_mask),
                .hex_i        (hex_mode),
                .hit_o        (ref_hit[gi])
            );
        end
    endgenerate

    // Synchronised, polarity corrected line level.
    logic rx_bit;
    line_sync u_sync (
        .clk_i        (clk_i),
        .reset_i      (reset_i),
        .line_i       (line_i),
        .active_low_i (ctrl[CTRL_POL_BIT]),
        .bit_o        (rx_bit)
    );

    // Bit timing and symbol assembly helpers.
    wire logic       tick       = (bit_cnt == 16'h0000);
    wire logic [15:0] half_div  = {1'b0, bit_div[15:1]};
    wire logic [15:0] full_div  = bit_div - 16'h0001;
    wire logic       idle_ok    = (idle_cnt >= idle_cyc);
    wire logic       start_seen = (state == RX_IDLE) && !rx_bit && (frame_open || idle_ok);
    wire logic       start_ok   = (state == RX_START) && tick && !rx_bit;
    wire logic       data_last  = (state == RX_DATA) && tick && (bit_idx == width - 4'd1);
    wire logic       exp_par    = (^sym_val) ^ (par_mode == PAR_ODD);
    wire logic       par_evt    = (state == RX_PARITY) && tick && (rx_bit != exp_par);
    wire logic       stop_evt   = (state == RX_STOP) && tick;
    wire logic       ferr_evt   = (stop_evt && !rx_bit)
                                  || ((state == RX_STOP2) && tick && !rx_bit);
    wire logic       sym_done   = stop_evt;
    wire logic       brk_evt    = (state == RX_BREAK) && !rx_bit && !brk_seen
                                  && (since_start >= break_cyc);
    wire logic       frame_end  = frame_open && (state == RX_IDLE) && rx_bit && idle_ok;
    wire logic       cap_fall   = cap_q && !capture_i;

    // Receiver state machine; bits are sampled at their centre, a half stop bit at its start.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state   <= RX_IDLE;
            bit_cnt <= 16'h0000;
            bit_idx <= 4'h0;
            shreg   <= 9'h000;
        end else begin
            bit_cnt <= tick ? 16'h0000 : bit_cnt - 16'h0001;
            case (state)
                RX_IDLE: if (start_seen) begin
                    state   <= RX_START;
                    bit_cnt <= half_div;
                end
                RX_START: if (tick) begin
                    // A short glitch that is high at mid-bit is not a start bit.
                    state   <= rx_bit ? RX_IDLE : RX_DATA;
                    bit_cnt <= full_div;
                    bit_idx <= 4'h0;
                end
                RX_DATA: if (tick) begin
                    shreg   <= {rx_bit, shreg[8:1]};
                    bit_idx <= bit_idx + 4'h1;
                    bit_cnt <= full_div;
                    if (data_last) state <= (par_mode == PAR_NONE) ? RX_STOP : RX_PARITY;
                end
                RX_PARITY: if (tick) begin
                    state   <= RX_STOP;
                    bit_cnt <= full_div;
                end
                RX_STOP: if (tick) begin
                    if (!rx_bit) state <= RX_BREAK;
                    else if (stop_len == STOP_ONE) state <= RX_IDLE;
                    else begin
                        state   <= RX_STOP2;
                        bit_cnt <= (stop_len == STOP_TWO) ? full_div : half_div;
                    end
                end
                RX_STOP2: if (tick) state <= rx_bit ? RX_IDLE : RX_BREAK;
                RX_BREAK: if (rx_bit) state <= RX_IDLE;
                default: state <= RX_IDLE;
            endcase
        end
    end

    // Time since start edge, idle time and frame boundary tracking.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            since_start <= 24'h000000;
            idle_cnt    <= 20'h00000;
            frame_open  <= 1'b0;
            new_frame   <= 1'b0;
            brk_seen    <= 1'b0;
        end else begin
            since_start <= start_seen ? 24'h000000
                         : (since_start == 24'hFFFFFF) ? since_start : since_start + 24'h000001;
            idle_cnt    <= (state != RX_IDLE || !rx_bit) ? 20'h00000
                         : idle_ok ? idle_cnt : idle_cnt + 20'h00001;
            if (start_seen) new_frame <= !frame_open;
            if (start_ok) frame_open <= 1'b1;
            else if (frame_end) frame_open <= 1'b0;
            if (start_seen) brk_seen <= 1'b0;
            else if (brk_evt) brk_seen <= 1'b1;
        end
    end

    // Symbol index and running pattern comparison.
    wire logic [12:0] rel     = sym_idx - {1'b0, pat_off};
    wire logic        in_pat  = (sym_idx >= {1'b0, pat_off}) && (rel < {11'h000, pat_cnt});
    wire logic        rel_hit = (rel[1:0] == 2'd3) ? 1'b0 : ref_hit[rel[1:0]];
    wire logic        pat_evt = sym_done && in_pat && (rel == {11'h000, pat_cnt} - 13'h0001)
                                && rel_hit && ((rel == 13'h0000) || pat_ok);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sym_idx <= 13'h0000;
            pat_ok  <= 1'b0;
            par_err <= 1'b0;
        end else begin
            if (start_ok && new_frame) sym_idx <= 13'h0000;
            else if (sym_done && sym_idx != 13'h1FFF) sym_idx <= sym_idx + 13'h0001;
            if (sym_done && in_pat) pat_ok <= (rel == 13'h0000) ? rel_hit : (pat_ok && rel_hit);
            if (par_evt) par_err <= 1'b1;
            else if (start_seen) par_err <= 1'b0;
        end
    end

    // Trigger selection; the pulse follows the qualifying sample by one cycle.
    logic trig_cond;
    always_comb begin
        case (mode)
            TM_START:    trig_cond = start_ok;
            TM_FRAME:    trig_cond = start_ok && new_frame;
            TM_NTH:      trig_cond = sym_done && (sym_idx == {1'b0, nth_num});
            TM_ANY:      trig_cond = sym_done && ref_hit[0];
            TM_PATTERN:  trig_cond = pat_evt;
            TM_PARITY:   trig_cond = par_evt && (par_mode != PAR_NONE);
            TM_FRAMEERR: trig_cond = ferr_evt;
            TM_BREAK:    trig_cond = brk_evt;
            default:     trig_cond = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            trigger_o <= 1'b0;
            break_o   <= 1'b0;
            trig_time <= 32'h00000000;
            tstamp    <= 32'h00000000;
        end else begin
            trigger_o <= enable && trig_cond;
            break_o   <= brk_seen || brk_evt;
            tstamp    <= tstamp + 32'h00000001;
            if (enable && trig_cond) trig_time <= tstamp;
        end
    end

    // Frame record: start time, data words and the state at closure.
    wire logic close_now = frame_open && (frame_end || cap_fall);
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            frame_o       <= '0;
            frame_valid_o <= 1'b0;
            cap_q         <= 1'b0;
            incomplete    <= 1'b0;
        end else begin
            cap_q         <= capture_i;
            frame_valid_o <= close_now;
            if (start_ok && new_frame) begin
                frame_o.start_time <= tstamp;
                frame_o.words      <= 13'h0000;
                incomplete         <= !capture_i;
            end else if (sym_done && frame_open) begin
                frame_o.last_word <= sym_val;
                if (frame_o.words != 13'h1FFF) frame_o.words <= frame_o.words + 13'h0001;
            end
            if (close_now) begin
                frame_o.state <= (cap_fall || incomplete) ? FS_INCOMPLETE
                               : (frame_o.words == 13'h0000) ? FS_BOUNDARY : FS_VALID;
            end
        end
    end

    // Word store; only the first WORDS symbols of a frame are kept.
    always_ff @(posedge clk_i) begin
        if (sym_done && frame_open && frame_o.words < 13'(WORDS)) begin
            words[frame_o.words[$clog2(WORDS)-1:0]] <= sym_val;
        end
    end

    // Read side; data stand in the cycle after the strobe only.
    wire logic [31:0] rel_time = frame_o.start_time - trig_time;
    logic [31:0] rd_mux;
    always_comb begin
        case (bus_i.addr)
            OFF_CTRL:  rd_mux = {16'h0000, ctrl};
            OFF_DIV:   rd_mux = {16'h0000, bit_div};
            OFF_IDLE:  rd_mux = {12'h000, idle_cyc};
            OFF_BREAK: rd_mux = {8'h00, break_cyc};
            OFF_NTH:   rd_mux = {20'h00000, nth_num};
            OFF_PAT:   rd_mux = {15'h0000, pat_cfg};
            OFF_STAT:  rd_mux = {11'h000, frame_o.state, par_err, brk_seen, frame_open,
                                 3'h0, sym_idx};
            OFF_REL:   rd_mux = rel_time;
            OFF_DATA:  rd_mux = {23'h000000, words[data_idx[$clog2(WORDS)-1:0]]};
            default:   rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= (reset_i || !bus_i.rd) ? 32'h00000000 : rd_mux;
    end

    // Checks on the receiver and trigger behaviour.
    start_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == TM_START && enable && start_ok) |=> trigger_o)
        else $error("start bit did not trigger");
    frame_once_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == TM_FRAME && start_ok && frame_open) |=> !trigger_o)
        else $error("frame start fired inside a frame");
    trig_single_a: assert property (@(posedge clk_i) disable iff (reset_i)
        trigger_o |=> !trigger_o)
        else $error("trigger pulse longer than one cycle");
    gap_guard_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == RX_IDLE && !frame_open && !idle_ok) |=> state != RX_START)
        else $error("start accepted inside idle gap");
    bit_centre_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == RX_IDLE && start_seen) |=> (state == RX_START && bit_cnt == half_div))
        else $error("start not timed to bit centre");
    parity_trig_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == TM_PARITY && enable && par_mode != PAR_NONE && par_evt) |=> trigger_o)
        else $error("parity error not triggered");
    stop_miss_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (state == RX_STOP && tick && !rx_bit) |=> state == RX_BREAK)
        else $error("missing stop bit not caught");
    break_flag_a: assert property (@(posedge clk_i) disable iff (reset_i)
        brk_evt |=> break_o)
        else $error("break not flagged");
    nth_symbol_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (mode == TM_NTH && enable && sym_done && sym_idx == {1'b0, nth_num}) |=> trigger_o)
        else $error("nth symbol missed");
endmodule : uart_trig_decoder

//--- verilog/uart_trig_pkg.sv
// Constants, types and register map of the asynchronous serial trigger decoder.
// Operation
// - Trigger on first zero after stop or idle.
// - Frame start fires only after idle.
// - Count symbols, fire on configured index.
// - Compare every symbol against reference, fire match.
// - Reference bits are one, zero or don't-care.
// - Hex entry masks whole symbol at once.
// - Pattern skips 0 to 4095 leading symbols.
// - Pattern of one to three symbols, all match.
// - Pattern uses configured five-to-nine bit width.
// - Fire when parity bit breaks parity rule.
// - Fire when stop bit is missing.
// - Flag break when no stop within limit.
// - Record frame start time and data words.
// - Frame state valid, boundary only, incomplete.
// - Start bits inside idle gap open nothing.
// - Parity none, even or odd, checked.
// - Stop length one, one half or two.
// - Line polarity active high or low.
package uart_trig_pkg;

    // Clock rate and default line rate.
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          BAUD_DEFAULT = 115_200;
    localparam logic [15:0] DIV_RESET    = 16'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [19:0] IDLE_RESET   = 20'h00F00;
    localparam logic [23:0] BREAK_RESET  = 24'h004000;
    localparam logic [15:0] CTRL_RESET   = 16'h0080;
    localparam logic [16:0] PAT_RESET    = 17'h01000;

    // Register byte addresses.
    localparam logic [7:0] OFF_CTRL  = 8'h00;
    localparam logic [7:0] OFF_DIV   = 8'h04;
    localparam logic [7:0] OFF_IDLE  = 8'h08;
    localparam logic [7:0] OFF_BREAK = 8'h0C;
    localparam logic [7:0] OFF_NTH   = 8'h10;
    localparam logic [7:0] OFF_PAT   = 8'h14;
    localparam logic [7:0] OFF_REF0  = 8'h18;
    localparam logic [7:0] OFF_STAT  = 8'h24;
    localparam logic [7:0] OFF_REL   = 8'h28;
    localparam logic [7:0] OFF_DATA  = 8'h2C;
    localparam logic [7:0] REF_STEP  = 8'h04;

    // Control, pattern and reference register fields, and the widest symbol.
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_POL_BIT  = 3;
    localparam int CTRL_WID_LSB  = 4;
    localparam int CTRL_PAR_LSB  = 8;
    localparam int CTRL_STOP_LSB = 10;
    localparam int CTRL_EN_BIT   = 12;
    localparam int PAT_CNT_LSB   = 12;
    localparam int PAT_HEX_BIT   = 16;
    localparam int REF_CARE_LSB  = 16;
    localparam int SYM_MAX       = 9;

    typedef enum logic [2:0] {
        TM_START, TM_FRAME, TM_NTH, TM_ANY, TM_PATTERN, TM_PARITY, TM_FRAMEERR, TM_BREAK
    } trig_mode_t;
    typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} parity_t;
    typedef enum logic [1:0] {STOP_ONE, STOP_ONE_HALF, STOP_TWO} stop_len_t;
    typedef enum logic [1:0] {FS_VALID, FS_BOUNDARY, FS_INCOMPLETE} frame_state_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } bus_req_t;

    typedef struct packed {
        logic [31:0]  start_time;
        logic [12:0]  words;
        logic [8:0]   last_word;
        frame_state_t state;
    } frame_rec_t;

endpackage : uart_trig_pkg
